// ### core/fat_pkg.sv
/*
 fast alarm timer package: register offsets, control field positions, reset values,
 state enum and the packed state struct of the timer core.
 assumes a 32-bit apb slave with word-aligned registers.
*/
package fat_pkg;
   // ----------------------------------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] FAT_OFF_UPPER = 8'h00;
   localparam logic [7:0] FAT_OFF_LOWER = 8'h04;
   localparam logic [7:0] FAT_OFF_MATCH = 8'h08;
   localparam logic [7:0] FAT_OFF_RELOAD = 8'h0C;
   localparam logic [7:0] FAT_OFF_CTRL = 8'h10;
   // ----------------------------------------------------------------
   // control field positions
   // ----------------------------------------------------------------
   localparam int FAT_B_TEN = 0;
   localparam int FAT_B_LAE = 1;
   localparam int FAT_B_SAE = 2;
   localparam int FAT_B_BUSY = 3;
   localparam int FAT_B_RDY = 4;
   localparam int FAT_B_RDYE = 5;
   localparam int FAT_B_LFL = 6;
   localparam int FAT_B_SFL = 7;
   localparam int FAT_B_WE = 15;
   // ----------------------------------------------------------------
   // widths, maxima and reset values
   // ----------------------------------------------------------------
   localparam int FAT_LOW_W = 12;
   localparam int FAT_MATCH_W = 20;
   localparam logic [11:0] FAT_LOW_MAX = 12'hFFF;
   localparam logic [31:0] FAT_ALL_ONES = 32'hFFFFFFFF;
   localparam logic [31:0] FAT_RST_WORD = 32'h00000000;
   localparam logic [11:0] FAT_LOW_RST = 12'h000;
   localparam logic [19:0] FAT_MATCH_RST = 20'h00000;
   localparam logic [31:0] FAT_ERR_DATA = 32'h00000000;

   // pending write kinds waiting for the next tick
   typedef enum logic [1:0] {
      FAT_IDLE = 2'b00,
      FAT_SYNC = 2'b01
   } fat_sync_e;

   // apb request bundle
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } fat_apb_req_s;

   // whole state of the core
   typedef struct packed {
      logic [31:0] upper;
      logic [11:0] lower;
      logic [19:0] match;
      logic [31:0] reload;
      logic [31:0] sa_cnt;
      logic ten;
      logic lae;
      logic sae;
      logic rdy;
      logic rdye;
      logic lfl;
      logic sfl;
      logic we;
      fat_sync_e sync;
      logic p_ten;
      logic p_lae;
      logic p_sae;
      logic p_upd;
      logic [31:0] p_upper;
      logic p_lowupd;
      logic [11:0] p_lower;
      logic sa_load;
      logic irq;
      logic wake;
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } fat_state_s;
endpackage

// ### core/fat_timer.sv
/*
 fast alarm timer core: 44-bit free running tick timer with long match alarm,
 auto-reload short alarm, busy write protection and ready read window, behind apb.
 assumes i_tick is a one-cycle pulse synchronous to i_clk_sys, one per fast timer tick.
*/
// The APB slave port was left to the implementer.
`timescale 1ns/100ps
// Summary of operation
// - upper count advances when the 12-bit lower count wraps to zero
// - lower count in bits 11:0 advances once per tick while enabled
// - counting continues until disabled; reads never change the count
// - with long alarm enabled, upper bits 19:0 equal match value sets long flag and interrupt
// - short alarm counter starts at reload and steps with each lower count change
// - short counter wrap to zero sets short flag and reloads at once
// - reload zero gives the full 32-bit alarm interval
// - enable delay affects only the first short alarm; later ones exact
// - busy set at reset, upper or lower count write and enable bit changes
// - while busy, protected control bits and count writes are blocked
// - pending write applied on next tick, then busy clears
// - ready clears one tick before carry ripple and sets right after
// - software may clear ready; it stays clear until next ripple
// - ready enable bit 5 raises interrupt when hardware sets ready
// - timer enable writes ignored unless write-unlock bit 15 already set
// - short flag bit 7 and long flag bit 6 drive wake-up while set
// - bits 2,1,0 enable short alarm, long alarm, timer; changes go via busy
module fat_timer (
   // clock, reset, enable
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_ce,
   // fast timer tick
   input wire logic i_tick,
   // apb slave
   input wire fat_pkg::fat_apb_req_s i_apb,
   output logic o_pready,
   output logic [31:0] o_prdata,
   output logic o_pslverr,
   // events
   output logic o_irq,
   output logic o_wake
);
   import fat_pkg::*;

   fat_state_s state_reg;
   fat_state_s state_next;
   logic acc;
   logic wr;
   logic busy;
   logic low_wrap;
   logic ripple_soon;
   logic [31:0] rd;
   logic [31:0] sa_inc;

   // ----------------------------------------------------------------
   // helper terms
   // ----------------------------------------------------------------
   // one-cycle access phase; reads have no side effects
   assign acc = i_apb.psel & i_apb.penable & ~state_reg.pready;
   assign wr = acc & i_apb.pwrite;
   assign busy = (state_reg.sync != FAT_IDLE);
   assign low_wrap = state_reg.ten & i_tick & (state_reg.lower == FAT_LOW_MAX);
   // the tick that brings the lower count to all ones opens the ripple
   assign ripple_soon = state_reg.ten & (state_reg.lower == (FAT_LOW_MAX - 12'h001));
   assign sa_inc = state_reg.sa_cnt + 32'h00000001;

   // read mux
   always_comb begin
      rd = FAT_ERR_DATA;
      case (i_apb.paddr)
         FAT_OFF_UPPER: rd = state_reg.upper;
         FAT_OFF_LOWER: rd = {20'h00000, state_reg.lower};
         FAT_OFF_MATCH: rd = {12'h000, state_reg.match};
         FAT_OFF_RELOAD: rd = state_reg.reload;
         FAT_OFF_CTRL: begin
            rd[FAT_B_TEN] = state_reg.ten;
            rd[FAT_B_LAE] = state_reg.lae;
            rd[FAT_B_SAE] = state_reg.sae;
            rd[FAT_B_BUSY] = busy;
            rd[FAT_B_RDY] = state_reg.rdy;
            rd[FAT_B_RDYE] = state_reg.rdye;
            rd[FAT_B_LFL] = state_reg.lfl;
            rd[FAT_B_SFL] = state_reg.sfl;
            rd[FAT_B_WE] = state_reg.we;
         end
         default: rd = FAT_ERR_DATA;
      endcase
   end

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      logic rdy_set;
      logic sa_wrap;
      logic [31:0] w;
      rdy_set = 1'b0;
      sa_wrap = 1'b0;
      w = i_apb.pwdata;
      state_next = state_reg;
      state_next.pready = acc;
      state_next.pslverr = 1'b0;
      state_next.prdata = state_reg.prdata;
      if (acc) begin
         state_next.prdata = i_apb.pwrite ? FAT_ERR_DATA : rd;
         state_next.pslverr = (rd == FAT_ERR_DATA) & (i_apb.paddr > FAT_OFF_CTRL);
      end
      // ripple window control
      if (i_tick & ripple_soon & ~low_wrap) begin
         state_next.rdy = 1'b0;
      end
      // lower/upper counting
      if (state_reg.ten & i_tick) begin
         state_next.lower = state_reg.lower + 12'h001;
         if (low_wrap) begin
            state_next.upper = state_reg.upper + 32'h00000001;
         end
         // short alarm counter steps with the lower count
         if (state_reg.sae & ~state_reg.sa_load) begin
            if (state_reg.sa_cnt == FAT_ALL_ONES) begin
               sa_wrap = 1'b1;
               state_next.sa_cnt = state_reg.reload; // reload at wrap
            end else begin
               state_next.sa_cnt = sa_inc;
            end
         end
      end
      // ready reasserts after the ripple completes
      if (state_reg.ten & i_tick & (state_reg.lower == FAT_LOW_RST) & ~state_reg.rdy) begin
         rdy_set = 1'b1;
      end
      // software writes
      if (wr) begin
         case (i_apb.paddr)
            FAT_OFF_UPPER: if (!busy) begin
               state_next.p_upd = 1'b1;
               state_next.p_upper = w;
               state_next.sync = FAT_SYNC;
            end
            FAT_OFF_LOWER: if (!busy) begin
               state_next.p_lowupd = 1'b1;
               state_next.p_lower = w[FAT_LOW_W-1:0];
               state_next.sync = FAT_SYNC;
            end
            FAT_OFF_MATCH: state_next.match = w[FAT_MATCH_W-1:0];
            FAT_OFF_RELOAD: state_next.reload = w;
            FAT_OFF_CTRL: begin
               state_next.we = w[FAT_B_WE];
               state_next.rdye = w[FAT_B_RDYE];
               if (!w[FAT_B_RDY]) begin
                  state_next.rdy = 1'b0; // software clear
               end
               // write zero clears flags, one
               if (!w[FAT_B_LFL]) begin
                  state_next.lfl = 1'b0;
               end
               if (!w[FAT_B_SFL]) begin
                  state_next.sfl = 1'b0;
               end
               if (!busy) begin
                  state_next.p_ten = state_reg.we ? w[FAT_B_TEN] : state_reg.ten;
                  state_next.p_lae = w[FAT_B_LAE];
                  state_next.p_sae = w[FAT_B_SAE];
                  if ((state_next.p_ten != state_reg.ten) | (w[FAT_B_LAE] != state_reg.lae)
                      | (w[FAT_B_SAE] != state_reg.sae)) begin
                     state_next.sync = FAT_SYNC; // change goes through busy
                  end
               end
            end
            default: state_next.sync = state_reg.sync;
         endcase
      end
      // ready set by hardware wins over a software clear
      if (rdy_set) begin
         state_next.rdy = 1'b1;
      end
      // alarm flags: set wins over clear
      if (state_reg.lae & (state_reg.upper[FAT_MATCH_W-1:0] == state_reg.match)) begin
         state_next.lfl = 1'b1;
      end
      if (sa_wrap) begin
         state_next.sfl = 1'b1;
      end
      // the short counter loads from the reload on the first tick after enabling
      if (i_tick & state_reg.sa_load) begin
         state_next.sa_cnt = state_reg.reload;
         state_next.sa_load = 1'b0;
      end
      // pending writes are applied on the next tick
      if (i_tick & busy) begin
         state_next.sync = FAT_IDLE;
         state_next.ten = state_reg.p_ten;
         state_next.lae = state_reg.p_lae;
         state_next.sae = state_reg.p_sae;
         state_next.sa_load = state_reg.p_sae & ~state_reg.sae;
         if (state_reg.p_upd) begin
            state_next.upper = state_reg.p_upper;
            state_next.p_upd = 1'b0;
         end
         if (state_reg.p_lowupd) begin
            state_next.lower = state_reg.p_lower;
            state_next.p_lowupd = 1'b0;
         end
      end
      // interrupt and wake outputs
      state_next.irq = (state_next.lfl & state_next.lae) | (state_next.sfl & state_next.sae)
                       | (rdy_set & state_reg.rdye);
      state_next.wake = state_next.lfl | state_next.sfl;
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         state_reg <= '0;
         state_reg.sync <= FAT_SYNC; // busy after reset
      end else if (i_ce) begin
         state_reg <= state_next;
      end
   end

   assign o_pready = state_reg.pready;
   assign o_prdata = state_reg.prdata;
   assign o_pslverr = state_reg.pslverr;
   assign o_irq = state_reg.irq;
   assign o_wake = state_reg.wake;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_upper_carry: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (i_ce & low_wrap & ~busy) |=> (state_reg.upper == $past(state_reg.upper) + 32'h00000001))
      else $error("upper count missed carry");
   a_lower_step: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (i_ce & i_tick & state_reg.ten & ~busy) |=>
      (state_reg.lower == $past(state_reg.lower) + 12'h001))
      else $error("lower count did not step");
   a_count_hold: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (i_ce & ~i_tick) |=> $stable(state_reg.lower))
      else $error("count moved without tick");
   a_long_flag: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (i_ce & state_reg.lae & (state_reg.upper[19:0] == state_reg.match)) |=> state_reg.lfl)
      else $error("long flag not set on match");
   a_short_reload: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (i_ce & i_tick & state_reg.ten & state_reg.sae & ~state_reg.sa_load & ~busy
       & (state_reg.sa_cnt == FAT_ALL_ONES)) |=> (state_reg.sfl & state_reg.sa_cnt == $past(state_reg.reload)))
      else $error("short alarm wrap wrong");
   a_busy_clear: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (i_ce & i_tick & busy) |=> ~busy)
      else $error("busy not cleared on tick");
   a_busy_block: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (i_ce & busy & ~i_tick) |=> $stable(state_reg.p_ten))
      else $error("write accepted while busy");
   a_wake_out: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (i_ce & state_reg.lae & (state_reg.upper[19:0] == state_reg.match)) |=> o_wake)
      else $error("wake not raised");
   a_ready_clear: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (i_ce & i_tick & state_reg.ten & (state_reg.lower == (FAT_LOW_MAX - 12'h001)))
      |=> ~state_reg.rdy)
      else $error("ready not cleared before ripple");
   a_ready_irq: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (i_ce & i_tick & state_reg.ten & state_reg.rdye & ~state_reg.rdy
       & (state_reg.lower == FAT_LOW_RST)) |=> (o_irq & state_reg.rdy))
      else $error("ready interrupt missing");
   c_long_alarm: cover property (@(posedge i_clk_sys) disable iff (i_rst) state_reg.lfl);
   c_short_alarm: cover property (@(posedge i_clk_sys) disable iff (i_rst) state_reg.sfl);
   c_ready_irq: cover property (@(posedge i_clk_sys) disable iff (i_rst)
      state_reg.rdye & $rose(state_reg.rdy));
endmodule

// ### testbench/test_fat_timer.sv
/*
 self-checking bench for the fast alarm timer: apb register access, counting, alarms.
 assumes the core answers each apb access by itself and syncs pending writes on i_tick.
*/
`timescale 1ns/100ps
module test_fat_timer;
   import fat_pkg::*;
   // ----------------------------------------------------------------
   // signals and table of plain register cases
   // ----------------------------------------------------------------
   typedef struct {
      logic [7:0] a;
      logic [31:0] d;
      logic [31:0] e;
   } fat_row_s;
   logic i_clk_sys, i_rst, i_ce, i_tick;
   fat_apb_req_s req;
   logic o_pready, o_pslverr, o_irq, o_wake, slverr;
   logic [31:0] o_prdata, rd, p;
   int errors, total_checks, n;
   fat_row_s rows [3] = '{'{FAT_OFF_MATCH, 32'hFFFFFFFF, 32'h000FFFFF},
      '{FAT_OFF_MATCH, 32'h00000006, 32'h00000006},
      '{FAT_OFF_RELOAD, 32'hFFFFFFFD, 32'hFFFFFFFD}};

   fat_timer i_dut (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .i_tick(i_tick),
      .i_apb(req),
      .o_pready(o_pready),
      .o_prdata(o_prdata),
      .o_pslverr(o_pslverr),
      .o_irq(o_irq),
      .o_wake(o_wake)
   );

   // ----------------------------------------------------------------
   // clock and watchdog
   // ----------------------------------------------------------------
   // 250 MHz system clock
   initial begin
      i_clk_sys = 1'b0;
      forever #2 i_clk_sys = ~i_clk_sys;
   end
   // cuts a hang short well past the expected run length of about 35k cycles
   initial begin
      #200000;
      errors++;
      end_of_test;
   end

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   // compare and count
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer; request held until pready is sampled high
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge i_clk_sys);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge i_clk_sys);
      req.penable <= 1'b1;
      do begin
         @(posedge i_clk_sys);
         k++;
      end while (o_pready !== 1'b1 && k < 50);
      if (k >= 50) begin
         errors++;
      end
      rd = o_prdata;
      slverr = o_pslverr;
      req <= '0;
   endtask
   // masked read compare
   task rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h00000000);
      chk(rd & m, e);
   endtask
   // one fast timer tick, then a short gap
   task tick;
      @(posedge i_clk_sys);
      i_tick <= 1'b1;
      @(posedge i_clk_sys);
      i_tick <= 1'b0;
      repeat (2) @(posedge i_clk_sys);
   endtask
   // verdict and end of run
   task end_of_test;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   // reset state first, then table cases, protection, alarms, ready window and mid-run reset
   initial begin
      i_rst = 1'b1;
      i_ce = 1'b1;
      i_tick = 1'b0;
      req = '0;
      errors = 0;
      total_checks = 0;
      repeat (6) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      chk(32'({o_irq, o_wake}), 32'h0);
      rdm(FAT_OFF_CTRL, 32'hFFFFFFFF, 32'h00000008);
      apb(1'b0, 8'h14, 32'h0);
      chk({31'h0, slverr}, 32'h1);
      chk(rd, FAT_ERR_DATA);
      rdm(FAT_OFF_RELOAD, 32'hFFFFFFFF, 32'h0);
      tick;
      rdm(FAT_OFF_CTRL, 32'hFFFFFFFF, 32'h0);
      // alarm registers are open to writes at any time
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, rows[i].a, rows[i].d);
         rdm(rows[i].a, 32'hFFFFFFFF, rows[i].e);
      end
      // load counts with the timer stopped
      apb(1'b1, FAT_OFF_LOWER, 32'h00000F00);
      tick;
      apb(1'b1, FAT_OFF_UPPER, 32'h00000005);
      rdm(FAT_OFF_CTRL, 32'h8, 32'h8);
      tick;
      rdm(FAT_OFF_UPPER, 32'hFFFFFFFF, 32'h5);
      rdm(FAT_OFF_LOWER, 32'hFFF, 32'hF00);
      rdm(FAT_OFF_LOWER, 32'hFFF, 32'hF00);
      // enable without unlock is ignored
      apb(1'b1, FAT_OFF_CTRL, 32'h00000001);
      tick;
      rdm(FAT_OFF_CTRL, 32'h1, 32'h0);
      apb(1'b1, FAT_OFF_CTRL, 32'h00008000);
      apb(1'b1, FAT_OFF_CTRL, 32'h00008005);
      rdm(FAT_OFF_CTRL, 32'h8, 32'h8);
      apb(1'b1, FAT_OFF_LOWER, 32'h00000123);
      tick;
      rdm(FAT_OFF_CTRL, 32'h800F, 32'h8005);
      apb(1'b0, FAT_OFF_LOWER, 32'h0);
      chk(rd & 32'hFFF, 32'h00000F00);
      // short alarm: first alarm, then exact reload interval
      n = 0;
      do begin
         tick;
         apb(1'b0, FAT_OFF_CTRL, 32'h0);
         n++;
      end while (rd[7] !== 1'b1 && n < 10);
      chk(32'(rd[7]), 32'h1);
      chk(32'({o_irq, o_wake}), 32'h3);
      apb(1'b1, FAT_OFF_CTRL, 32'h00008015);
      for (int i = 1; i <= 3; i++) begin
         tick;
         apb(1'b0, FAT_OFF_CTRL, 32'h0);
         chk(32'({rd[7], o_irq}), (i == 3) ? 32'h3 : 32'h0);
      end
      // long alarm and ready window around the carry ripple
      apb(1'b1, FAT_OFF_CTRL, 32'h00008023);
      tick;
      apb(1'b0, FAT_OFF_LOWER, 32'h0);
      p = rd;
      // clock enable low freezes the count through a tick
      i_ce <= 1'b0;
      tick;
      i_ce <= 1'b1;
      rdm(FAT_OFF_LOWER, 32'hFFF, p & 32'hFFF);
      tick;
      rdm(FAT_OFF_LOWER, 32'hFFF, (p + 32'h1) & 32'hFFF);
      n = 0;
      do begin
         tick;
         apb(1'b0, FAT_OFF_LOWER, 32'h0);
         n++;
      end while (rd[11:0] !== 12'hFFF && n < 300);
      rdm(FAT_OFF_CTRL, 32'h10, 32'h0);
      tick;
      rdm(FAT_OFF_LOWER, 32'hFFF, 32'h0);
      rdm(FAT_OFF_UPPER, 32'hFFFFFFFF, 32'h6);
      rdm(FAT_OFF_CTRL, 32'h40, 32'h40);
      chk(32'({o_irq, o_wake}), 32'h3);
      tick;
      rdm(FAT_OFF_CTRL, 32'h10, 32'h10);
      apb(1'b1, FAT_OFF_CTRL, 32'h00008063);
      rdm(FAT_OFF_CTRL, 32'h10, 32'h0);
      tick;
      rdm(FAT_OFF_CTRL, 32'h10, 32'h0);
      // ready stays clear through the next wrap, then hardware sets it
      repeat (4095) tick;
      rdm(FAT_OFF_CTRL, 32'h10, 32'h10);
      rdm(FAT_OFF_UPPER, 32'hFFFFFFFF, 32'h7);
      // ready drops on the tick that brings the lower count to all ones
      repeat (4093) tick;
      rdm(FAT_OFF_LOWER, 32'hFFF, 32'hFFE);
      rdm(FAT_OFF_CTRL, 32'h10, 32'h10);
      tick;
      rdm(FAT_OFF_CTRL, 32'h10, 32'h0);
      // reset in mid-run: busy again, lower count back to its reset value
      i_rst <= 1'b1;
      repeat (2) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      rdm(FAT_OFF_CTRL, 32'hFFFFFFFF, 32'h00000008);
      rdm(FAT_OFF_LOWER, 32'hFFFFFFFF, 32'(FAT_LOW_RST));
      end_of_test;
   end
endmodule
